// ==== elr_event_link_router.sv ====
// Purpose: event link router with port group and single port linking
// Assumes: all sources are one-cycle pulses on CLK; pins are synchronous
// Notes: register map over classic Wishbone, one wait state per access
`timescale 1ns/1ps
`default_nettype none
module elr_event_link_router
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire elr_pkg::elr_wb_req_s WB_I,
  output logic WB_ACK,
  output logic [elr_pkg::WB_DW-1:0] WB_DAT_O,
  input wire logic [elr_pkg::NCODE-1:0] EVT_IN,
  input wire logic [elr_pkg::PW-1:0] PORT_B_IN,
  input wire logic [elr_pkg::PW-1:0] PORT_E_IN,
  output logic [elr_pkg::PW-1:0] PORT_B_OUT,
  output logic [elr_pkg::PW-1:0] PORT_E_OUT,
  output logic [elr_pkg::PW-1:0] PORT_B_OE,
  output logic [elr_pkg::PW-1:0] PORT_E_OE,
  output logic [elr_pkg::NLINK-1:0] EVT_OUT,
  output logic [elr_pkg::NINT-1:0] INT_REQ,
  output logic [elr_pkg::ACT_W-1:0] TIMER_MODE,
  output logic STOPPED
);
  import elr_pkg::*;

  logic ack_q;
  logic [WB_DW-1:0] rdat_q;
  logic [WB_DW-1:0] rd;
  logic stop_q;
  logic [ACT_W-1:0] act_q;
  logic [CW-1:0] sel_q [NLINK];
  logic [CW-1:0] pel_q [NSGL];
  logic [PW-1:0] pgr_q [NGRP];
  logic [CW-1:0] pgc_q [NGRP];
  logic [PW-1:0] pdbf_q [NGRP];
  logic [PW-1:0] pdbf_d [NGRP];
  logic [PW-1:0] prev_q [NGRP];
  logic [PW-1:0] out_q [NGRP];
  logic [PW-1:0] out_d [NGRP];
  logic [PW-1:0] pin_in [NGRP];
  logic [PW-1:0] oe [NGRP];
  logic [1:0] sgl_port [NSGL];
  logic [PINW-1:0] sgl_pin [NSGL];
  logic [NLINK-1:0] evt_q;
  logic [NLINK-1:0] hit_v;
  logic [NLINK-1:0] sel_legal;
  logic [NGRP-1:0] grp_evt;
  logic [NSGL-1:0] sgl_evt;
  logic [NCODE-1:0] src;

  wire [5:0] widx = WB_I.adr[ADR_W-1:WIDX_LSB];
  wire bus_req = WB_I.cyc & WB_I.stb & ~ack_q;
  // writes land on the edge where ack is sampled, never earlier
  wire wr_en = WB_I.cyc & WB_I.stb & WB_I.we & ack_q;
  wire wr_b0 = wr_en & WB_I.sel[LANE0];
  wire wr_b1 = wr_en & WB_I.sel[LANE1];
  wire sw_pulse = wr_b0 & (widx == WIDX_CTRL) & WB_I.dat[CTRL_SW];

  function automatic logic [PW-1:0] edge_hit(input logic [PW-1:0] cur, input logic [PW-1:0] prv,
                                             input logic [1:0] mode);
    if (mode == EDGE_RISE)
    begin
      return cur & ~prv;
    end
    if (mode == EDGE_FALL)
    begin
      return ~cur & prv;
    end
    return cur ^ prv;
  endfunction

  function automatic logic code_ok(input logic [CW-1:0] c);
    return (c[CW-1] == 1'b0) && LEGAL_MASK[c[CODE_IDX_W-1:0]];
  endfunction

  assign pin_in[0] = PORT_B_IN;
  assign pin_in[1] = PORT_E_IN;

  genvar g, m, i;
  generate
    for (g = 0; g < NGRP; g++)
    begin : g_grp
      assign oe[g] = pgc_q[g][PGC_DIR] ? pgr_q[g] : '0;
      assign grp_evt[g] = |(edge_hit(pin_in[g], prev_q[g], pgc_q[g][PGC_EDGE_HI:PGC_EDGE_LO])
                            & pgr_q[g] & ~oe[g]);
    end
    for (m = 0; m < NSGL; m++)
    begin : g_sgl
      wire grp = (sgl_port[m] == PORT_E);
      wire on = (sgl_port[m] == PORT_B) | (sgl_port[m] == PORT_E);
      wire [PW-1:0] eh = edge_hit(pin_in[grp], prev_q[grp], pel_q[m][PEL_ACT_HI:PEL_ACT_LO]);
      assign sgl_port[m] = pel_q[m][PEL_PORT_HI:PEL_PORT_LO];
      assign sgl_pin[m] = pel_q[m][PEL_PIN_HI:PEL_PIN_LO];
      assign sgl_evt[m] = on & eh[sgl_pin[m]] & ~oe[grp][sgl_pin[m]];
    end
  endgenerate

  always_comb
  begin
    src = EVT_IN;
    for (int k = 0; k < NGRP; k++)
    begin
      src[CODE_GRP_IN + k] = grp_evt[k];
    end
    for (int k = 0; k < NSGL; k++)
    begin
      src[CODE_SGL_IN + k] = sgl_evt[k];
    end
    src[CODE_SW] = sw_pulse;
  end

  generate
    for (i = 0; i < NLINK; i++)
    begin : g_link
      wire [CODE_IDX_W-1:0] ci = sel_q[i][CODE_IDX_W-1:0];
      assign sel_legal[i] = code_ok(sel_q[i]);
      assign hit_v[i] = sel_legal[i] & src[ci];
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          sel_q[i] <= RST_BYTE;
        else if (wr_b0 && widx == LINK_NUM[i])
          sel_q[i] <= WB_I.dat[CW-1:0];
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      evt_q <= '0;
    else
      evt_q <= stop_q ? '0 : hit_v;
  end

  assign EVT_OUT = evt_q;
  assign INT_REQ = {evt_q[SLOT_INT2], evt_q[SLOT_INT1], evt_q[SLOT_LPT]};
  assign TIMER_MODE = act_q;
  assign STOPPED = stop_q;
  assign PORT_B_OUT = out_q[0];
  assign PORT_E_OUT = out_q[1];
  assign PORT_B_OE = oe[0];
  assign PORT_E_OE = oe[1];

  // group buffer and outputs
  // capture wins over a software write to the buffer in the same cycle
  always_comb
  begin
    for (int k = 0; k < NGRP; k++)
    begin
      pdbf_d[k] = pdbf_q[k];
      if (wr_b0 && widx == WIDX_PDBF + k)
        pdbf_d[k] = WB_I.dat[PW-1:0];
      if (evt_q[SLOT_GIN + k])
        pdbf_d[k] = (pdbf_q[k] & ~pgr_q[k]) | (pin_in[k] & pgr_q[k]);
      out_d[k] = out_q[k];
      if (evt_q[SLOT_GOUT + k])
        out_d[k] = (out_q[k] & ~pgr_q[k]) | (pdbf_q[k] & pgr_q[k]);
      for (int n = 0; n < NSGL; n++)
      begin
        if (evt_q[SLOT_SOUT + n] && sgl_port[n] == GRP_PORT[k])
        begin
          unique case (pel_q[n][PEL_ACT_HI:PEL_ACT_LO])
            ACT_LOW: out_d[k][sgl_pin[n]] = 1'b0;
            ACT_HIGH: out_d[k][sgl_pin[n]] = 1'b1;
            ACT_TOG: out_d[k][sgl_pin[n]] = ~out_q[k][sgl_pin[n]];
            ACT_HOLD: out_d[k][sgl_pin[n]] = out_q[k][sgl_pin[n]];
          endcase
        end
      end
    end
  end

  // prev keeps tracking during stop so release makes no stale edge
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int k = 0; k < NGRP; k++)
      begin
        pgr_q[k] <= RST_BYTE;
        pgc_q[k] <= RST_BYTE;
        pdbf_q[k] <= RST_BYTE;
        prev_q[k] <= RST_BYTE;
        out_q[k] <= RST_BYTE;
      end
    end
    else
    begin
      for (int k = 0; k < NGRP; k++)
      begin
        if (wr_b0 && widx == WIDX_PGR + k)
          pgr_q[k] <= WB_I.dat[PW-1:0];
        if (wr_b0 && widx == WIDX_PGC + k)
          pgc_q[k] <= WB_I.dat[CW-1:0] & PGC_MASK;
        pdbf_q[k] <= pdbf_d[k];
        prev_q[k] <= pin_in[k];
        out_q[k] <= out_d[k];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int k = 0; k < NSGL; k++)
        pel_q[k] <= RST_BYTE;
      stop_q <= 1'b0;
      act_q <= '0;
    end
    else
    begin
      for (int k = 0; k < NSGL; k++)
      begin
        if (wr_b0 && widx == WIDX_PEL + k)
          pel_q[k] <= WB_I.dat[CW-1:0] & PEL_MASK;
      end
      if (wr_b0 && widx == WIDX_CTRL)
        stop_q <= WB_I.dat[CTRL_STOP];
      if (wr_b0 && widx == WIDX_ACT)
        act_q[CW-1:0] <= WB_I.dat[CW-1:0];
      if (wr_b1 && widx == WIDX_ACT)
        act_q[ACT_W-1:CW] <= WB_I.dat[ACT_W-1:CW];
    end
  end

  // unmapped words read as zero and still acknowledge
  always_comb
  begin
    rd = '0;
    for (int k = 0; k < NLINK; k++)
    begin
      if (widx == LINK_NUM[k])
        rd[CW-1:0] = sel_q[k];
    end
    for (int k = 0; k < NSGL; k++)
    begin
      if (widx == WIDX_PEL + k)
        rd[CW-1:0] = pel_q[k];
    end
    for (int k = 0; k < NGRP; k++)
    begin
      if (widx == WIDX_PGR + k)
        rd[PW-1:0] = pgr_q[k];
      if (widx == WIDX_PGC + k)
        rd[CW-1:0] = pgc_q[k];
      if (widx == WIDX_PDBF + k)
        rd[PW-1:0] = pdbf_q[k];
    end
    if (widx == WIDX_CTRL)
      rd[CTRL_STOP] = stop_q;
    if (widx == WIDX_ACT)
      rd[ACT_W-1:0] = act_q;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end
    else
    begin
      ack_q <= bus_req;
      if (bus_req)
        rdat_q <= rd;
    end
  end
  assign WB_ACK = ack_q;
  assign WB_DAT_O = rdat_q;

  property p_latency;
    @(posedge CLK) disable iff (!RST_N) !stop_q |=> (EVT_OUT == $past(hit_v));
  endproperty
  a_latency: assert property (p_latency)
    else $error("link output not one cycle after source");

  property p_legal;
    @(posedge CLK) disable iff (!RST_N) (EVT_OUT & ~$past(sel_legal)) == '0;
  endproperty
  a_legal: assert property (p_legal)
    else $error("prohibited code produced an event");

  property p_stop;
    @(posedge CLK) disable iff (!RST_N) stop_q [*2] |-> (EVT_OUT == '0) && (INT_REQ == '0);
  endproperty
  a_stop: assert property (p_stop)
    else $error("event passed during module stop");

  property p_int;
    @(posedge CLK) disable iff (!RST_N) hit_v[SLOT_LPT] && !stop_q |=> INT_REQ[0];
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt request missing");

  property p_port_dec;
    @(posedge CLK) disable iff (!RST_N) (sgl_port[0] == ~PORT_OFF || sgl_port[0] == PORT_OFF) |-> !sgl_evt[0];
  endproperty
  a_port_dec: assert property (p_port_dec)
    else $error("single event from disabled or prohibited port");

  property p_grp_edge;
    @(posedge CLK) disable iff (!RST_N)
      pgc_q[0][PGC_EDGE_HI] && ((pin_in[0] ^ prev_q[0]) & pgr_q[0] & ~oe[0]) != '0
      |-> grp_evt[0] ##1 ($past(stop_q) || $past(sel_q[SLOT_INT2]) != 8'(CODE_GRP_IN) || INT_REQ[2]);
  endproperty
  a_grp_edge: assert property (p_grp_edge)
    else $error("group pin change gave no event");

  property p_capture;
    @(posedge CLK) disable iff (!RST_N) evt_q[SLOT_GIN] |=>
      pdbf_q[0] == (($past(pdbf_q[0]) & ~$past(pgr_q[0])) | ($past(pin_in[0]) & $past(pgr_q[0])));
  endproperty
  a_capture: assert property (p_capture)
    else $error("group buffer not captured");

  property p_sw;
    @(posedge CLK) disable iff (!RST_N)
      sw_pulse && !stop_q && sel_q[SLOT_INT1] == 8'(CODE_SW) |=> EVT_OUT[SLOT_INT1];
  endproperty
  a_sw: assert property (p_sw)
    else $error("software event not delivered");

  property p_sgl_out;
    @(posedge CLK) disable iff (!RST_N)
      evt_q[SLOT_SOUT] && sgl_port[0] == PORT_B && pel_q[0][PEL_ACT_HI:PEL_ACT_LO] == ACT_TOG
      |=> out_q[0][$past(sgl_pin[0])] == !$past(out_q[0][sgl_pin[0]]);
  endproperty
  a_sgl_out: assert property (p_sgl_out)
    else $error("single pin output not set");
endmodule // elr_event_link_router
`default_nettype wire

// ==== elr_pkg.sv ====
// Purpose: shared constants and types for the event link router
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: codes at and above the table size are never legal
package elr_pkg;
  localparam int WB_DW = 32;
  localparam int ADR_W = 8;
  localparam int WIDX_LSB = 2;
  localparam int LANE0 = 0;
  localparam int LANE1 = 1;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [WB_DW-1:0] dat;
  } elr_wb_req_s;

  localparam int CW = 8;
  localparam int CODE_IDX_W = 7;
  localparam int NCODE = 128;
  // bit c set when event code c is a legal selection
  localparam logic [NCODE-1:0] LEGAL_MASK = 128'h0000_07FF_F97F_C000_3C36_471C_87FF_FF00;
  localparam int CODE_GRP_IN = 32'h63;
  localparam int CODE_SGL_IN = 32'h65;
  localparam int CODE_SW = 32'h69;

  localparam int NLINK = 23;
  localparam int NINT = 3;
  localparam int NGRP = 2;
  localparam int NSGL = 4;
  localparam int PW = 8;
  localparam int PINW = 3;
  // link number of each destination slot; link n sits at byte 4*n
  localparam logic [5:0] LINK_NUM [NLINK] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08,
    6'h0A, 6'h0C, 6'h0F, 6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
    6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h2E};
  localparam int SLOT_LPT = 5;
  localparam int SLOT_INT1 = 10;
  localparam int SLOT_INT2 = 11;
  localparam int SLOT_GOUT = 12;
  localparam int SLOT_GIN = 14;
  localparam int SLOT_SOUT = 16;
  localparam int ACT_W = 14;

  localparam logic [5:0] WIDX_PEL = 6'h30;
  localparam logic [5:0] WIDX_PGR = 6'h34;
  localparam logic [5:0] WIDX_PGC = 6'h36;
  localparam logic [5:0] WIDX_PDBF = 6'h38;
  localparam logic [5:0] WIDX_CTRL = 6'h3A;
  localparam logic [5:0] WIDX_ACT = 6'h3B;

  localparam int PEL_PIN_LO = 0;
  localparam int PEL_PIN_HI = 2;
  localparam int PEL_PORT_LO = 3;
  localparam int PEL_PORT_HI = 4;
  localparam int PEL_ACT_LO = 5;
  localparam int PEL_ACT_HI = 6;
  localparam logic [CW-1:0] PEL_MASK = 8'h7F;
  localparam int PGC_EDGE_LO = 0;
  localparam int PGC_EDGE_HI = 1;
  localparam int PGC_DIR = 2;
  localparam logic [CW-1:0] PGC_MASK = 8'h07;
  localparam int CTRL_STOP = 0;
  localparam int CTRL_SW = 1;

  localparam logic [1:0] PORT_OFF = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_E = 2'h2;
  localparam logic [1:0] GRP_PORT [NGRP] = '{2'h1, 2'h2};
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_TOG = 2'h2;
  localparam logic [1:0] ACT_HOLD = 2'h3;
  localparam logic [CW-1:0] RST_BYTE = 8'h00;
endpackage

// ==== elr_src_model.sv ====
// Purpose: peripheral source model raising one-cycle event pulses
// Assumes: the bench asks for one pulse by event code
// Notes: one source fires per request, held high for as many cycles as FIRE is held
`timescale 1ns/1ps
`default_nettype none
module elr_src_model
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic FIRE,
  input wire logic [elr_pkg::CODE_IDX_W-1:0] CODE,
  output logic [elr_pkg::NCODE-1:0] EVT
);
  import elr_pkg::*;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      EVT <= '0;
    end
    else
    begin
      EVT <= FIRE ? (128'h1 << CODE) : '0;
    end
  end
endmodule // elr_src_model
`default_nettype wire

// ==== elr_event_link_router_tb.sv ====
// Purpose: register-level test of the event link router
// Assumes: one wait state per bus access, sources from elr_src_model
// Notes: codes that other links use are kept distinct so pulses stay one-hot
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module elr_event_link_router_tb;
  import elr_pkg::*;
  logic CLK, RST_N, ack, fire, stopped;
  elr_wb_req_s wb;
  logic [31:0] dout, rdat;
  logic [6:0] code;
  logic [127:0] evt_in;
  logic [7:0] pb, pe, pbo, peo, peoe, pboe;
  logic [22:0] evt_out;
  logic [2:0] int_req;
  logic [13:0] tmode;
  int fail_count, n_compared, cyc_n;
  localparam logic [6:0] OK_C [19] = '{7'h08, 7'h1A, 7'h1F, 7'h22, 7'h2A, 7'h2E, 7'h31, 7'h34,
    7'h35, 7'h3A, 7'h3D, 7'h4E, 7'h51, 7'h52, 7'h56, 7'h58, 7'h5B, 7'h62, 7'h6A};
  localparam logic [6:0] BAD_C [4] = '{7'h07, 7'h20, 7'h57, 7'h7F};
  elr_src_model SRC (.CLK(CLK), .RST_N(RST_N), .FIRE(fire), .CODE(code), .EVT(evt_in));
  elr_event_link_router DUT (.CLK(CLK), .RST_N(RST_N), .WB_I(wb), .WB_ACK(ack), .WB_DAT_O(dout),
    .EVT_IN(evt_in), .PORT_B_IN(pb), .PORT_E_IN(pe), .PORT_B_OUT(pbo), .PORT_E_OUT(peo),
    .PORT_B_OE(pboe), .PORT_E_OE(peoe), .EVT_OUT(evt_out), .INT_REQ(int_req), .TIMER_MODE(tmode),
    .STOPPED(stopped));
  always #2.5 CLK = ~CLK;
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cut a hang short; a normal run needs well under a thousand cycles
  always @(posedge CLK)
  begin
    cyc_n++;
    if (cyc_n == 4000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do
    begin
      @(posedge CLK);
    end
    while (ack !== 1'b1);
    rdat = dout;
    wb <= '0;
    // the write lands on this edge; callers look at outputs only once it has settled
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK("read data", e, rdat)
  endtask
  // source pulse, then the routed pulse one cycle after the router sees it
  task automatic ev(input logic [6:0] c, input logic [22:0] eo, input logic [2:0] ei);
    @(posedge CLK);
    fire <= 1'b1;
    code <= c;
    @(posedge CLK);
    fire <= 1'b0;
    @(posedge CLK);
    #1;
    `CHK("evt_out", eo, evt_out)
    `CHK("int_req", ei, int_req)
    @(posedge CLK);
    #1;
    `CHK("evt_out end", 23'h0, evt_out)
  endtask
  task automatic pin(input logic [7:0] v, input logic [2:0] ei);
    @(posedge CLK);
    pb <= v;
    @(posedge CLK);
    #1;
    `CHK("pin int_req", ei, int_req)
  endtask
  initial
  begin
    CLK = 0; RST_N = 0; wb = '0; fire = 0; code = '0; pb = '0; pe = '0;
    fail_count = 0; n_compared = 0; cyc_n = 0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'hC0, 32'h0);
    `CHK("stopped", 1'b0, stopped)
    rd(8'h00, 32'h0);
    acc(1'b1, 8'h00, 32'hFF);
    rd(8'h00, 32'h0);
    acc(1'b1, 8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'hFF);
    acc(1'b1, 8'hC4, 32'hFF);
    rd(8'hC4, 32'h7F);
    acc(1'b1, 8'hEC, 32'h3FFF);
    `CHK("timer mode", 14'h3FFF, tmode)
    for (int i = 0; i < 19; i++)
    begin
      acc(1'b1, 8'h1C, {25'h0, OK_C[i]});
      ev(OK_C[i], 23'h10, 3'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 8'h1C, {25'h0, BAD_C[i]});
      ev(BAD_C[i], 23'h0, 3'h0);
    end
    acc(1'b1, 8'h1C, 32'h0);
    acc(1'b1, 8'h20, 32'h32);
    ev(7'h32, 23'h20, 3'h1);
    acc(1'b1, 8'h48, 32'h69);
    acc(1'b1, 8'hE8, 32'h2);
    `CHK("sw event", 23'h400, evt_out)
    `CHK("sw int", 3'h2, int_req)
    acc(1'b1, 8'hE8, 32'h1);
    `CHK("stopped", 1'b1, stopped)
    ev(7'h32, 23'h0, 3'h0);
    acc(1'b1, 8'hE8, 32'h0);
    acc(1'b1, 8'h4C, 32'h63);
    acc(1'b1, 8'hD0, 32'h0F);
    acc(1'b1, 8'hD8, 32'h02);
    `CHK("port b oe", 8'h00, pboe)
    pin(8'h02, 3'h4);
    pin(8'h82, 3'h0);
    pin(8'h80, 3'h4);
    pin(8'h85, 3'h4);
    acc(1'b1, 8'h58, 32'h0C);
    ev(7'h0C, 23'h4000, 3'h0);
    rd(8'hE0, 32'h05);
    acc(1'b1, 8'hD4, 32'hF0);
    acc(1'b1, 8'hDC, 32'h04);
    acc(1'b1, 8'hE4, 32'hA5);
    `CHK("port e oe", 8'hF0, peoe)
    acc(1'b1, 8'h54, 32'h0D);
    ev(7'h0D, 23'h2000, 3'h0);
    `CHK("port e out", 8'hA0, peo)
    acc(1'b1, 8'hC0, 32'h4A);
    acc(1'b1, 8'h60, 32'h0E);
    ev(7'h0E, 23'h10000, 3'h0);
    `CHK("port b out", 8'h04, pbo)
    ev(7'h0E, 23'h10000, 3'h0);
    `CHK("port b out", 8'h00, pbo)
    tally_and_finish();
  end
endmodule // elr_event_link_router_tb
`default_nettype wire
